// file: src/cme_cfg.svh
// constants for the command mode entry and exit block
`ifndef CME_CFG_SVH
`define CME_CFG_SVH

// binary command codes
`define CME_CODE_GUARD_BEFORE  8'h04
`define CME_CODE_GUARD_AFTER   8'h05
`define CME_CODE_TIMEOUT       8'h06
`define CME_CODE_EXIT          8'h09
`define CME_CODE_ESC_CHAR      8'h13
`define CME_CODE_BAUD          8'h15
`define CME_CODE_AUX_TWO       8'h1F
`define CME_CODE_AUX_THREE     8'h28

// reset values
`define CME_RST_ESC_CHAR       8'h2B
`define CME_RST_TIMEOUT        16'h00C8
`define CME_RST_GUARD          16'h000A
`define CME_RST_AUX_SEL        8'h00
`define CME_RST_BAUD           16'h0003

// legal ranges
`define CME_ESC_MIN            8'h20
`define CME_ESC_MAX            8'h7F
`define CME_TIME_MIN           16'h0002
`define CME_BAUD_STD_MAX       16'h0006
`define CME_BAUD_NSTD_MIN      16'h007D
`define CME_AUX_TWO_MAX        8'h04
`define CME_AUX_THREE_MAX      8'h04
`define CME_SAT16              16'hFFFF
`define CME_ONE16              16'h0001

// selector encodings
`define CME_SEL_0              8'h00
`define CME_SEL_1              8'h01
`define CME_SEL_2              8'h02
`define CME_SEL_3              8'h03
`define CME_SEL_4              8'h04

// time base: one count of every time parameter is 100 ms
`define CME_TICK_NS            100000000
`define CME_CLK_NS             10
`define CME_TICK_CYCLES        (`CME_TICK_NS / `CME_CLK_NS)

`endif

// file: src/cme_pkg.sv
// types shared by the command mode entry and exit block
package cme_pkg;

   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_ESC  = 2'b01,
      MODE_CMD  = 2'b10
   } cme_mode_t;

   typedef struct packed {
      logic        valid;
      logic        wr;
      logic [7:0]  code;
      logic [15:0] data;
   } cme_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        ok;
      logic [15:0] data;
   } cme_rsp_t;

   typedef struct packed {
      logic        flow_ok;
      logic        tx_active;
      logic        rx_indicate;
      logic        own_pkt_sent;
   } cme_line_t;

   typedef struct packed {
      cme_mode_t   mode;
      logic [15:0] sil;
      logic [15:0] lead_sil;
      logic [15:0] trail_sil;
      logic [15:0] idle_tmo;
      logic [7:0]  esc;
      logic [7:0]  sel_two;
      logic [7:0]  sel_three;
      logic [15:0] baud;
      logic [15:0] baud_pend;
      cme_rsp_t    rsp;
   } cme_state_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } cme_tick_st_t;

   typedef struct packed {
      logic two;
      logic three;
   } cme_aux_st_t;

endpackage

// file: src/cme_tick.sv
// restartable 100 ms time base
`timescale 1ns/1ps
`include "cme_cfg.svh"

module cme_tick
   import cme_pkg::*;
#(
   parameter int TICK_CYCLES = `CME_TICK_CYCLES
)
(
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic restart,
   output logic      tick
);

   cme_tick_st_t st_ff;
   cme_tick_st_t nxt_st;

   // restarting keeps silence measured from the last byte, not from a free phase
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (restart)
      begin
         nxt_st.cnt = '0;
      end
      else if (st_ff.cnt == 32'(TICK_CYCLES - 1))
      begin
         nxt_st.cnt  = '0;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign tick = st_ff.tick;

endmodule

// file: src/cme_aux.sv
// auxiliary output line drivers
`timescale 1ns/1ps
`include "cme_cfg.svh"

module cme_aux
   import cme_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [7:0] sel_two,
   input  wire logic [7:0] sel_three,
   input  wire cme_line_t  line,
   output logic            aux_output_two,
   output logic            aux_output_three
);

   cme_aux_st_t st_ff;
   cme_aux_st_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      case (sel_two)
         `CME_SEL_0: nxt_st.two = line.flow_ok;
         `CME_SEL_1: nxt_st.two = ~line.tx_active;
         `CME_SEL_2: nxt_st.two = 1'b1;
         `CME_SEL_3: nxt_st.two = line.tx_active;
         `CME_SEL_4: nxt_st.two = 1'b0;
         default:    nxt_st.two = line.flow_ok;
      endcase
      case (sel_three)
         `CME_SEL_0: nxt_st.three = line.rx_indicate;
         `CME_SEL_1: nxt_st.three = 1'b1;
         `CME_SEL_2: nxt_st.three = 1'b0;
         `CME_SEL_4: nxt_st.three = line.own_pkt_sent;
         // reserved selector leaves the line low
         default:    nxt_st.three = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign aux_output_two   = st_ff.two;
   assign aux_output_three = st_ff.three;

endmodule

// file: src/cme_top.sv
// command mode entry and exit control for the host serial interface
//
// Function
// - escape character accepts only 0x20 to 0x7F, stored in one byte
// - escape character resets to the plus sign 0x2B
// - only the configured character between both silences counts as escape
// - silence, escape character, silence in idle enters command mode
// - leading silence in 100 ms counts, default ten counts
// - trailing silence in 100 ms counts, default one second
// - escape character is reached by command code 0x13
// - third output follows its selector: indicator, high, low, reserved, own packet
// - selector 4 asserts third output only while own-addressed packet is sent
// - exit command 0x09 in command mode returns to idle at once
// - new baud selection waits pending until the exit command runs
// - second output follows selector: clear-to-send, enable low, high, enable high, low
// - second output selector resets to 0, clear-to-send
// - timeout is 16 bits, 0x02 to 0xFFFF, in 100 ms counts
// - timeout resets to 0xC8, twenty seconds
// - no activity for the timeout leaves command mode to idle
// - timeout is code 0x06, second output selector is code 0x1F
`timescale 1ns/1ps
`include "cme_cfg.svh"

module cme_top
   import cme_pkg::*;
#(
   parameter int TICK_CYCLES = `CME_TICK_CYCLES
)
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_byte,
   input  wire cme_cmd_t   cmd,
   input  wire cme_line_t  line,
   output cme_rsp_t        rsp,
   output logic            cmd_mode,
   output logic [15:0]     host_baud,
   output logic            aux_output_two,
   output logic            aux_output_three
);

   cme_state_t st_ff;
   cme_state_t nxt_st;
   logic       tick;
   logic       activity;
   logic       restart;
   logic       esc_hit;
   logic       wr_ok;
   logic [7:0] data_lo;
   logic       hi_zero;
   logic       ok_esc;
   logic       ok_time;
   logic       ok_sel_two;
   logic       ok_sel_three;
   logic       ok_baud;
   logic       in_cmd;
   logic       lead_ok;
   logic       trail_ok;
   logic       tmo_hit;
   logic       exit_ok;

   assign activity = rx_valid | cmd.valid;
   assign data_lo  = cmd.data[7:0];

   // the time base restarts on any byte or mode change, so every
   // silence and timeout is measured in whole counts from that moment
   assign restart = activity | (nxt_st.mode != st_ff.mode);

   cme_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .mclk    (mclk),
      .rstn    (rstn),
      .restart (restart),
      .tick    (tick)
   );

   // escape byte must match the stored character exactly
   assign esc_hit = rx_valid && (rx_byte == st_ff.esc);

   // one legality test per parameter, shared by every write and refusal path
   assign hi_zero      = (cmd.data[15:8] == 8'h00);
   assign ok_esc       = hi_zero && (data_lo >= `CME_ESC_MIN)
                         && (data_lo <= `CME_ESC_MAX);
   assign ok_time      = (cmd.data >= `CME_TIME_MIN);
   assign ok_sel_two   = hi_zero && (data_lo <= `CME_AUX_TWO_MAX);
   assign ok_sel_three = hi_zero && (data_lo <= `CME_AUX_THREE_MAX);
   // standard table entries or a direct non-standard rate
   assign ok_baud      = (cmd.data <= `CME_BAUD_STD_MAX)
                         || (cmd.data >= `CME_BAUD_NSTD_MIN);

   // legality of the data word for the addressed parameter
   always_comb
   begin
      case (cmd.code)
         `CME_CODE_ESC_CHAR:     wr_ok = ok_esc;
         `CME_CODE_TIMEOUT:      wr_ok = ok_time;
         `CME_CODE_GUARD_BEFORE: wr_ok = ok_time;
         `CME_CODE_GUARD_AFTER:  wr_ok = ok_time;
         `CME_CODE_AUX_TWO:      wr_ok = ok_sel_two;
         `CME_CODE_AUX_THREE:    wr_ok = ok_sel_three;
         `CME_CODE_BAUD:         wr_ok = ok_baud;
         default:                wr_ok = 1'b0;
      endcase
   end

   // guard and timeout compares use the silence count as it stood before this edge
   assign in_cmd   = (st_ff.mode == MODE_CMD);
   assign lead_ok  = (st_ff.sil >= st_ff.lead_sil);
   assign trail_ok = (st_ff.sil >= st_ff.trail_sil);
   assign tmo_hit  = in_cmd && !activity && (st_ff.sil >= st_ff.idle_tmo);
   assign exit_ok  = cmd.valid && (cmd.code == `CME_CODE_EXIT) && in_cmd;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rsp = '0;

      // silence counter, saturating, cleared by any host activity
      if (activity)
      begin
         nxt_st.sil = '0;
      end
      else if (tick && (st_ff.sil != `CME_SAT16))
      begin
         nxt_st.sil = st_ff.sil + `CME_ONE16;
      end

      case (st_ff.mode)
         MODE_IDLE:
         begin
            // leading silence checked before the byte clears the counter
            if (esc_hit && lead_ok)
            begin
               nxt_st.mode = MODE_ESC;
            end
         end
         MODE_ESC:
         begin
            // any further byte breaks the trailing silence
            if (rx_valid)
            begin
               nxt_st.mode = MODE_IDLE;
            end
            else if (trail_ok)
            begin
               nxt_st.mode = MODE_CMD;
               nxt_st.sil  = '0;
            end
         end
         MODE_CMD:
         begin
            // a byte on this edge is activity and so outruns the timeout
            if (tmo_hit)
            begin
               nxt_st.mode = MODE_IDLE;
            end
         end
         default:
         begin
            nxt_st.mode = MODE_IDLE;
         end
      endcase

      if (cmd.valid)
      begin
         nxt_st.rsp.valid = 1'b1;
         nxt_st.rsp.ok    = 1'b1;
         case (cmd.code)
            `CME_CODE_ESC_CHAR:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.esc = data_lo;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = {8'h00, nxt_st.esc};
            end
            `CME_CODE_TIMEOUT:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.idle_tmo = cmd.data;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = nxt_st.idle_tmo;
            end
            `CME_CODE_GUARD_BEFORE:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.lead_sil = cmd.data;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = nxt_st.lead_sil;
            end
            `CME_CODE_GUARD_AFTER:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.trail_sil = cmd.data;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = nxt_st.trail_sil;
            end
            `CME_CODE_AUX_TWO:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.sel_two = data_lo;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = {8'h00, nxt_st.sel_two};
            end
            `CME_CODE_AUX_THREE:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.sel_three = data_lo;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = {8'h00, nxt_st.sel_three};
            end
            `CME_CODE_BAUD:
            begin
               if (cmd.wr)
               begin
                  if (wr_ok)
                     nxt_st.baud_pend = cmd.data;
                  else
                     nxt_st.rsp.ok = 1'b0;
               end
               // reads show the pending value, the live one is on host_baud
               nxt_st.rsp.data = nxt_st.baud_pend;
            end
            `CME_CODE_EXIT:
            begin
               // exit outside command mode is refused and changes nothing
               if (exit_ok)
               begin
                  nxt_st.mode = MODE_IDLE;
                  nxt_st.baud = st_ff.baud_pend;
               end
               else
               begin
                  nxt_st.rsp.ok = 1'b0;
               end
               nxt_st.rsp.data = '0;
            end
            default:
            begin
               nxt_st.rsp.ok   = 1'b0;
               nxt_st.rsp.data = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff.mode      <= MODE_IDLE;
         st_ff.sil       <= '0;
         st_ff.lead_sil  <= `CME_RST_GUARD;
         st_ff.trail_sil <= `CME_RST_GUARD;
         st_ff.idle_tmo  <= `CME_RST_TIMEOUT;
         st_ff.esc       <= `CME_RST_ESC_CHAR;
         st_ff.sel_two   <= `CME_RST_AUX_SEL;
         st_ff.sel_three <= `CME_RST_AUX_SEL;
         st_ff.baud      <= `CME_RST_BAUD;
         st_ff.baud_pend <= `CME_RST_BAUD;
         st_ff.rsp       <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   cme_aux u_aux (
      .mclk             (mclk),
      .rstn             (rstn),
      .sel_two          (st_ff.sel_two),
      .sel_three        (st_ff.sel_three),
      .line             (line),
      .aux_output_two   (aux_output_two),
      .aux_output_three (aux_output_three)
   );

   assign rsp       = st_ff.rsp;
   assign cmd_mode  = in_cmd;
   assign host_baud = st_ff.baud;

endmodule

// file: test/cme_chk.sv
// assertion checker for the command mode entry and exit block
`timescale 1ns/1ps
`include "cme_cfg.svh"

module cme_chk
   import cme_pkg::*;
#(
   parameter int TICK_CYCLES = 4
)
(
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_byte,
   input wire cme_cmd_t    cmd,
   input wire cme_line_t   line,
   input wire cme_rsp_t    rsp,
   input wire logic        cmd_mode,
   input wire logic [15:0] host_baud,
   input wire logic        aux_output_two,
   input wire logic        aux_output_three
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   logic exit_req;
   logic wr_esc;
   assign exit_req = cmd.valid && (cmd.code == `CME_CODE_EXIT);
   assign wr_esc   = cmd.valid && cmd.wr && (cmd.code == `CME_CODE_ESC_CHAR);

   sequence s_exit;
      exit_req && cmd_mode;
   endsequence
   sequence s_idle_ok;
      !cmd_mode && rsp.valid && rsp.ok;
   endsequence

   property p_exit;
      s_exit |=> s_idle_ok;
   endproperty
   property p_exit_refused;
      exit_req && !cmd_mode |=> rsp.valid && !rsp.ok;
   endproperty
   property p_baud_hold;
      $changed(host_baud) |-> $past(exit_req) && $past(cmd_mode);
   endproperty
   property p_esc_range;
      wr_esc && (cmd.data < 16'h0020 || cmd.data > 16'h007F) |=> rsp.valid && !rsp.ok;
   endproperty
   property p_esc_ok;
      wr_esc && cmd.data >= 16'h0020 && cmd.data <= 16'h007F
         |=> rsp.ok && rsp.data == $past(cmd.data);
   endproperty
   property p_time_range;
      cmd.valid && cmd.wr && cmd.code == `CME_CODE_TIMEOUT && cmd.data < 16'h0002
         |=> rsp.valid && !rsp.ok;
   endproperty
   property p_sel_range;
      cmd.valid && cmd.wr && cmd.data > 16'h0004
         && (cmd.code == `CME_CODE_AUX_TWO || cmd.code == `CME_CODE_AUX_THREE)
         |=> rsp.valid && !rsp.ok;
   endproperty
   property p_entry_quiet;
      $rose(cmd_mode) |-> !$past(rx_valid);
   endproperty
   property p_byte_keeps;
      cmd_mode && rx_valid && !exit_req |=> cmd_mode;
   endproperty

   a_exit: assert property (p_exit)
      else $error("exit command did not return to idle");
   a_exit_refused: assert property (p_exit_refused)
      else $error("exit outside command mode was accepted");
   a_baud_hold: assert property (p_baud_hold)
      else $error("baud changed without exit command");
   a_esc_range: assert property (p_esc_range)
      else $error("escape character out of range accepted");
   a_esc_ok: assert property (p_esc_ok)
      else $error("legal escape character write not stored");
   a_time_range: assert property (p_time_range)
      else $error("timeout below range accepted");
   a_sel_range: assert property (p_sel_range)
      else $error("selector above range accepted");
   a_entry_quiet: assert property (p_entry_quiet)
      else $error("command mode entered right after a byte");
   a_byte_keeps: assert property (p_byte_keeps)
      else $error("command mode left right after a byte");
endmodule

bind cme_top cme_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .mclk             (mclk),
   .rstn             (rstn),
   .rx_valid         (rx_valid),
   .rx_byte          (rx_byte),
   .cmd              (cmd),
   .line             (line),
   .rsp              (rsp),
   .cmd_mode         (cmd_mode),
   .host_baud        (host_baud),
   .aux_output_two   (aux_output_two),
   .aux_output_three (aux_output_three)
);

// file: test/cme_host.sv
// host side model: sends serial bytes to the block one at a time
`timescale 1ns/1ps

module cme_host
(
   input  wire logic  mclk,
   output logic       rx_valid,
   output logic [7:0] rx_byte
);
   initial
   begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
   end

   // held for one rising edge; afterwards the lines show the inverse so a stale
   // byte can never pass for a new one
   task automatic send(input logic [7:0] b);
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_byte  = b;
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_byte  = ~b;
   endtask

   task automatic quiet(input int n);
      repeat (n) @(negedge mclk);
   endtask
endmodule

// file: test/test_command_mode_entry_exit.sv
// testbench for the command mode entry and exit block
`timescale 1ns/1ps
`include "cme_cfg.svh"

module test_command_mode_entry_exit
   import cme_pkg::*;
;
   localparam int TK = 4;
   logic        mclk;
   logic        rstn;
   cme_cmd_t    cmd;
   cme_line_t   line;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   cme_rsp_t    rsp;
   logic        cmd_mode;
   logic [15:0] host_baud;
   logic        aux_output_two;
   logic        aux_output_three;
   int          fails;
   int          n_checks;

   cme_top #(.TICK_CYCLES(TK)) dut (
      .mclk(mclk), .rstn(rstn), .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd(cmd),
      .line(line), .rsp(rsp), .cmd_mode(cmd_mode), .host_baud(host_baud),
      .aux_output_two(aux_output_two), .aux_output_three(aux_output_three));
   cme_host host (.mclk(mclk), .rx_valid(rx_valid), .rx_byte(rx_byte));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // dc skips the data compare where the answer carries no defined value
   task automatic op(input logic wr, input logic [7:0] code, input logic [15:0] d,
                     input logic ok, input logic [15:0] exp, input bit dc = 1'b0);
      @(negedge mclk);
      cmd = {1'b1, wr, code, d};
      @(posedge mclk);
      #1;
      check({rsp.valid, rsp.ok, dc ? 16'h0000 : rsp.data}, {1'b1, ok, exp});
      @(negedge mclk);
      cmd = {1'b0, ~wr, ~code, ~d};
   endtask

   task automatic wait_mode(input logic v, input int n);
      for (int i = 0; i < n && cmd_mode !== v; i++)
         @(negedge mclk);
   endtask

   task automatic enter();
      host.quiet(3 * TK);
      host.send(8'h2B);
      host.quiet(2 * TK - 2);
      check(cmd_mode, 1'b0);
      wait_mode(1'b1, 2 * TK);
      check(cmd_mode, 1'b1);
   endtask

   function automatic logic [1:0] aux_exp(input int s, input cme_line_t l);
      logic [4:0] two;
      logic [4:0] three;
      two   = {1'b0, l.tx_active, 1'b1, ~l.tx_active, l.flow_ok};
      three = {l.own_pkt_sent, 1'b0, 1'b0, 1'b1, l.rx_indicate};
      return {two[s], three[s]};
   endfunction

   initial
   begin
      #100us;
      fails++;
      print_verdict();
   end

   initial
   begin
      rstn     = 1'b0;
      cmd      = '0;
      line     = '0;
      fails    = 0;
      n_checks = 0;
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      op(1'b0, 8'h06, 16'h0000, 1'b1, 16'h00C8);
      op(1'b0, 8'h13, 16'h0000, 1'b1, 16'h002B);
      op(1'b0, 8'h1F, 16'h0000, 1'b1, 16'h0000);
      op(1'b0, 8'h28, 16'h0000, 1'b1, 16'h0000);
      op(1'b0, 8'h04, 16'h0000, 1'b1, 16'h000A);
      op(1'b0, 8'h05, 16'h0000, 1'b1, 16'h000A);
      $display("test reset values done");
      op(1'b1, 8'h13, 16'h001F, 1'b0, 16'h002B);
      op(1'b1, 8'h13, 16'h0080, 1'b0, 16'h002B);
      op(1'b1, 8'h13, 16'h007F, 1'b1, 16'h007F);
      op(1'b1, 8'h13, 16'h0020, 1'b1, 16'h0020);
      op(1'b1, 8'h13, 16'h002B, 1'b1, 16'h002B);
      op(1'b1, 8'h06, 16'h0001, 1'b0, 16'h00C8);
      op(1'b1, 8'h06, 16'hFFFF, 1'b1, 16'hFFFF);
      op(1'b1, 8'h1F, 16'h0005, 1'b0, 16'h0000);
      op(1'b1, 8'h28, 16'h0005, 1'b0, 16'h0000);
      op(1'b1, 8'h06, 16'h0003, 1'b1, 16'h0003);
      op(1'b1, 8'h04, 16'h0002, 1'b1, 16'h0002);
      op(1'b1, 8'h05, 16'h0002, 1'b1, 16'h0002);
      $display("test ranges done");
      host.quiet(3 * TK);
      host.send(8'h41);
      host.quiet(4 * TK);
      check(cmd_mode, 1'b0);
      // escape right behind another byte lacks its leading silence
      host.send(8'h41);
      host.send(8'h2B);
      host.quiet(4 * TK);
      check(cmd_mode, 1'b0);
      // a byte inside the trailing silence breaks the sequence
      host.quiet(3 * TK);
      host.send(8'h2B);
      host.quiet(TK);
      host.send(8'h20);
      host.quiet(4 * TK);
      check(cmd_mode, 1'b0);
      enter();
      repeat (4)
      begin
         host.quiet(2 * TK);
         host.send(8'h41);
      end
      host.quiet(2 * TK);
      check(cmd_mode, 1'b1);
      wait_mode(1'b0, 3 * TK);
      check(cmd_mode, 1'b0);
      $display("test entry and timeout done");
      enter();
      op(1'b1, 8'h15, 16'h0005, 1'b1, 16'h0005);
      check(host_baud, 16'h0003);
      op(1'b1, 8'h09, 16'h0000, 1'b1, 16'h0000, 1'b1);
      check({cmd_mode, host_baud}, {1'b0, 16'h0005});
      op(1'b1, 8'h09, 16'h0000, 1'b0, 16'h0000, 1'b1);
      $display("test exit done");
      for (int s = 0; s < 5; s++)
      begin
         op(1'b1, 8'h1F, 16'(s), 1'b1, 16'(s));
         op(1'b1, 8'h28, 16'(s), 1'b1, 16'(s));
         for (int p = 0; p < 16; p += 5)
         begin
            line = cme_line_t'(4'(p));
            @(negedge mclk);
            check({aux_output_two, aux_output_three}, aux_exp(s, line));
         end
      end
      $display("test aux lines done");
      print_verdict();
   end
endmodule
